// [rtl/blp_power_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module blp_power_ctrl #(
	parameter int unsigned SETTLE = blp_pkg::SETTLE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wait_instr,
	input wire logic stop_instr,
	input wire logic wait_to_stop_select,
	input wire logic irq_enable_bit,
	input wire logic bus_active,
	input wire logic msg_received_ok,
	input wire logic eof_detected,
	input wire logic rx_in_progress,
	input wire logic tx_data_in,
	input wire logic tx_drive_in,
	output logic tx_data_out,
	output logic tx_drive_out,
	output logic in_wait,
	output logic in_stop,
	output logic clocks_run,
	output logic irq_req,
	output logic nmi_req,
	output logic wake_rx_valid,
	output logic comm_hold
);
	typedef struct packed {
		blp_pkg::blp_mode_e mode;
		logic eof_seen;
		logic via_wait;
		logic rx_ok;
		logic hold;
		logic [blp_pkg::CNT_W-1:0] cnt;
		logic irq;
		logic nmi;
		logic txd;
		logic txe;
		logic run_clk;
	} blp_state_s;

	blp_state_s st_q;
	blp_state_s st_d;
	logic bus_rise;

	// Bus edge detector
	blp_sync_edge u_edge (
		.ref_clk(ref_clk),
		.reset(reset),
		.bus_active(bus_active),
		.rise_pulse(bus_rise)
	);

	// Mode sequencing and wake handling
	always_comb begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.nmi = 1'b0;
		// Track end-of-frame since last message activity
		if (eof_detected) begin
			st_d.eof_seen = 1'b1;
		end else if (rx_in_progress) begin
			st_d.eof_seen = 1'b0;
		end
		if (st_q.hold) begin
			// Clocks restarting after stop wake
			if (st_q.cnt == blp_pkg::CNT_W'(SETTLE - 1)) begin
				st_d.hold = 1'b0;
				st_d.cnt = blp_pkg::RST_CNT;
			end else begin
				st_d.cnt = st_q.cnt + 1'b1;
			end
		end
		case (st_q.mode)
			blp_pkg::BLP_RUN: begin
				if (stop_instr || (wait_instr && wait_to_stop_select)) begin
					st_d.mode = blp_pkg::BLP_STOP;
					st_d.via_wait = wait_instr & ~stop_instr;
					// Byte kept only via wait with prior EOF and idle rx
					st_d.rx_ok = wait_instr & ~stop_instr & st_q.eof_seen
						& ~rx_in_progress;
				end else if (wait_instr) begin
					st_d.mode = blp_pkg::BLP_WAIT;
				end
			end
			blp_pkg::BLP_WAIT: begin
				// Clocks run, so a completed message wakes us
				if (msg_received_ok) begin
					st_d.mode = blp_pkg::BLP_RUN;
					st_d.irq = irq_enable_bit;
					st_d.rx_ok = 1'b1;
				end
			end
			blp_pkg::BLP_STOP: begin
				if (bus_rise) begin
					st_d.mode = blp_pkg::BLP_RUN;
					st_d.nmi = 1'b1;
					st_d.hold = 1'b1;
					st_d.cnt = blp_pkg::RST_CNT;
				end
			end
			default: st_d.mode = blp_pkg::BLP_RUN;
		endcase
		// No drive while in wait or stop, or during settling
		st_d.txe = tx_drive_in && (st_d.mode == blp_pkg::BLP_RUN)
			&& !st_d.hold;
		st_d.txd = tx_data_in & st_d.txe;
		st_d.run_clk = st_d.mode != blp_pkg::BLP_STOP;
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
			st_q.mode <= blp_pkg::BLP_RUN;
			st_q.run_clk <= 1'b1;
			st_q.eof_seen <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign tx_data_out = st_q.txd;
	assign tx_drive_out = st_q.txe;
	assign in_wait = st_q.mode[1]; // One-hot wait bit
	assign in_stop = st_q.mode[2]; // One-hot stop bit
	assign clocks_run = st_q.run_clk;
	assign irq_req = st_q.irq;
	assign nmi_req = st_q.nmi;
	assign wake_rx_valid = st_q.rx_ok;
	assign comm_hold = st_q.hold;

	// Wait entry from run with the select bit clear
	a_wait_entry: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && wait_instr && !stop_instr
		&& !wait_to_stop_select) |=> in_wait)
		else $error("wait entry missed");
	// No drive outside run
	a_no_drive: assert property (
		@(posedge ref_clk) disable iff (reset)
		(in_wait || in_stop) |-> !tx_drive_out)
		else $error("bus driven in low power");
	// Data line held low in wait
	a_wait_quiet: assert property (
		@(posedge ref_clk) disable iff (reset)
		in_wait |-> !tx_data_out)
		else $error("data shown in wait");
	// Wake from wait
	a_wait_wake: assert property (
		@(posedge ref_clk) disable iff (reset)
		(in_wait && msg_received_ok) |=> !in_wait
		&& (irq_req == $past(irq_enable_bit)))
		else $error("wait wake wrong");
	// Wait only ends on a good message
	a_wait_stays: assert property (
		@(posedge ref_clk) disable iff (reset)
		(in_wait && !msg_received_ok) |=> in_wait)
		else $error("wait left early");
	// Clocks in wait
	a_wait_clk: assert property (
		@(posedge ref_clk) disable iff (reset)
		in_wait |-> clocks_run)
		else $error("clocks stopped in wait");
	// Message that ends wait is kept
	a_wait_rx: assert property (
		@(posedge ref_clk) disable iff (reset)
		(in_wait && msg_received_ok) |=> wake_rx_valid)
		else $error("wait message lost");
	// Stop entry
	a_stop_entry: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && (stop_instr
		|| (wait_instr && wait_to_stop_select))) |=> in_stop && !clocks_run)
		else $error("stop entry missed");
	// Clocks halted for the whole stop
	a_stop_clk: assert property (
		@(posedge ref_clk) disable iff (reset)
		in_stop |-> !clocks_run)
		else $error("clocks run in stop");
	sequence s_stop_edge;
		in_stop ##1 (in_stop && bus_rise);
	endsequence
	// Edge wake
	a_stop_wake: assert property (
		@(posedge ref_clk) disable iff (reset)
		s_stop_edge |=> nmi_req && !in_stop && comm_hold)
		else $error("stop wake wrong");
	// Stop only ends on a bus edge
	a_stop_stays: assert property (
		@(posedge ref_clk) disable iff (reset)
		(in_stop && !bus_rise) |=> in_stop)
		else $error("stop left early");
	// Stop instruction loses byte
	a_stop_rx: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && stop_instr) |=> !wake_rx_valid)
		else $error("stop byte marked valid");
	// Wait-to-stop without EOF loses byte
	a_eof_rx: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && wait_instr && wait_to_stop_select
		&& !st_q.eof_seen) |=> !wake_rx_valid)
		else $error("byte valid without eof");
	// Wait-to-stop after end-of-frame keeps byte
	a_eof_keep: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && wait_instr && wait_to_stop_select
		&& !stop_instr && st_q.eof_seen && !rx_in_progress)
		|=> wake_rx_valid)
		else $error("byte lost after eof");
	// Entry during reception loses the message
	a_mid_rx: assert property (
		@(posedge ref_clk) disable iff (reset)
		(st_q.mode == blp_pkg::BLP_RUN && rx_in_progress && (stop_instr
		|| (wait_instr && wait_to_stop_select))) |=> !wake_rx_valid)
		else $error("mid-frame byte marked valid");
	// Settling starts with the wake interrupt
	a_wake_hold: assert property (
		@(posedge ref_clk) disable iff (reset)
		$rose(comm_hold) |-> nmi_req)
		else $error("hold without wake");
	// No drive while clocks settle
	a_hold_drive: assert property (
		@(posedge ref_clk) disable iff (reset)
		comm_hold |-> !tx_drive_out)
		else $error("bus driven while settling");
	// Hold releases after settle
	a_settle: assert property (
		@(posedge ref_clk) disable iff (reset)
		$rose(comm_hold) |-> ##[1:300] !comm_hold)
		else $error("hold never released");
endmodule
`default_nettype wire

// [common/blp_pkg.sv]
// Summary of operation
// - Wait instruction with wait-to-stop select clear enters wait mode from run.
// - In wait mode the controller drives no data onto the bus.
// - Wait mode wakes on a good message; interrupt if enable was set.
// - Internal clocks keep running in wait mode so the message is kept.
// - Stop instruction, or wait with select set, enters stop mode from run.
// - In stop mode a passive-to-active bus edge wakes with unmaskable interrupt.
// - Stop entered by stop instruction need not receive the waking message.
// - Stop via wait keeps waking byte only if end-of-frame seen before.
// - Stop entered mid-reception wakes on next edge, holds off until clocks settle.
package blp_pkg;

	// Power state, one-hot
	typedef enum logic [2:0] {
		BLP_RUN = 3'h1,
		BLP_WAIT = 3'h2,
		BLP_STOP = 3'h4
	} blp_mode_e;

	// Clock restart settle time after stop wake
	localparam int unsigned SETTLE_NS = 1000;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SETTLE_CYC =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;

	// Reset values
	localparam logic RST_FLAG = 1'b0;
	localparam logic [CNT_W-1:0] RST_CNT = 8'h00;

endpackage

// [rtl/blp_sync_edge.sv]
`timescale 1ns/1ns
`default_nettype none
module blp_sync_edge (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic bus_active,
	output logic rise_pulse
);
	typedef struct packed {
		logic prev;
		logic pulse;
	} blp_edge_s;

	blp_edge_s st_q;
	blp_edge_s st_d;

	// Passive-to-active detection of the bus level
	always_comb begin
		st_d = st_q;
		st_d.prev = bus_active;
		st_d.pulse = bus_active & ~st_q.prev;
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise_pulse = st_q.pulse;
endmodule
`default_nettype wire

// [verification/blp_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
module blp_bus_model (
	input wire logic ref_clk,
	input wire logic start,
	output logic bus_active,
	output logic msg_received_ok,
	output logic eof_detected,
	output logic rx_in_progress
);
	// One frame: three active cycles, then message-ok and end-of-frame
	initial begin
		{bus_active, msg_received_ok, eof_detected, rx_in_progress} = 4'h0;
		forever begin
			do @(posedge ref_clk); while (start !== 1'b1);
			#10 {bus_active, rx_in_progress} = 2'h3;
			repeat (3) @(posedge ref_clk);
			#10 {bus_active, rx_in_progress} = 2'h0;
			{msg_received_ok, eof_detected} = 2'h3;
			@(posedge ref_clk);
			#10 {msg_received_ok, eof_detected} = 2'h0;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_blp_power_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_blp_power_ctrl;
	logic ref_clk, reset, wait_instr, stop_instr, sel, ie, start;
	logic bus_active, msg_ok, eof, rx_busy, tx_data_in, tx_drive_in;
	logic tx_data_out, tx_drive_out, in_wait, in_stop, clocks_run;
	logic irq_req, nmi_req, wake_rx_valid, comm_hold;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	blp_power_ctrl #(.SETTLE(2)) i_blp_power_ctrl (.ref_clk(ref_clk),
		.reset(reset), .wait_instr(wait_instr), .stop_instr(stop_instr),
		.wait_to_stop_select(sel), .irq_enable_bit(ie),
		.bus_active(bus_active), .msg_received_ok(msg_ok),
		.eof_detected(eof), .rx_in_progress(rx_busy),
		.tx_data_in(tx_data_in), .tx_drive_in(tx_drive_in),
		.tx_data_out(tx_data_out), .tx_drive_out(tx_drive_out),
		.in_wait(in_wait), .in_stop(in_stop), .clocks_run(clocks_run),
		.irq_req(irq_req), .nmi_req(nmi_req),
		.wake_rx_valid(wake_rx_valid), .comm_hold(comm_hold));
	blp_bus_model i_blp_bus_model (.ref_clk(ref_clk), .start(start),
		.bus_active(bus_active), .msg_received_ok(msg_ok),
		.eof_detected(eof), .rx_in_progress(rx_busy));
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			give_verdict;
		end
	end
	task automatic chk(input logic a, input logic e);
		checks++;
		if (a !== e) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask
	// Pulse an instruction for one cycle; mode shows one cycle later
	task automatic instr(input logic w, input logic s, input logic m);
		{wait_instr, stop_instr, sel} = {w, s, m};
		step(1);
		{wait_instr, stop_instr} = 2'h0;
	endtask
	// Send a frame, then wait bounded for the wake pulse
	task automatic frame_wake(input logic nmi);
		start = 1'b1;
		step(1);
		start = 1'b0;
		for (int i = 0; i < 20; i++) begin
			step(1);
			if ((nmi ? nmi_req : irq_req) === 1'b1) break;
		end
	endtask
	task automatic t_wait;
		chk(clocks_run, 1'b1);
		chk(in_wait | in_stop, 1'b0);
		step(1);
		chk(tx_drive_out, 1'b1);
		chk(tx_data_out, 1'b1);
		ie = 1'b1;
		instr(1'b1, 1'b0, 1'b0);
		chk(in_wait, 1'b1);
		chk(tx_drive_out, 1'b0);
		chk(tx_data_out, 1'b0);
		chk(clocks_run, 1'b1);
		frame_wake(1'b0);
		chk(irq_req, 1'b1);
		chk(in_wait, 1'b0);
		chk(wake_rx_valid, 1'b1);
		$display("wait test done");
	endtask
	// Wait wake with the enable clear: wake, but no interrupt
	task automatic t_wait_masked;
		ie = 1'b0;
		instr(1'b1, 1'b0, 1'b0);
		chk(in_wait, 1'b1);
		start = 1'b1;
		step(1);
		start = 1'b0;
		step(3);
		chk(in_wait, 1'b1);
		step(1);
		chk(in_wait, 1'b0);
		chk(irq_req, 1'b0);
		chk(wake_rx_valid, 1'b1);
		$display("masked wait test done");
	endtask
	task automatic t_stop;
		ie = 1'b0;
		tx_drive_in = 1'b0;
		instr(1'b0, 1'b1, 1'b0);
		chk(in_stop, 1'b1);
		chk(clocks_run, 1'b0);
		frame_wake(1'b1);
		chk(nmi_req, 1'b1);
		chk(comm_hold, 1'b1);
		chk(wake_rx_valid, 1'b0);
		step(1);
		chk(nmi_req, 1'b0);
		chk(comm_hold, 1'b1);
		step(1);
		chk(comm_hold, 1'b0);
		$display("stop test done");
	endtask
	task automatic t_wait_stop;
		instr(1'b1, 1'b0, 1'b1);
		chk(in_stop, 1'b1);
		chk(in_wait, 1'b0);
		frame_wake(1'b1);
		chk(wake_rx_valid, 1'b1);
		$display("wait-to-stop test done");
	endtask
	// Wait-to-stop while a frame is on the bus, woken by the next frame
	task automatic t_mid;
		step(4);
		start = 1'b1;
		step(1);
		start = 1'b0;
		step(1);
		instr(1'b1, 1'b0, 1'b1);
		chk(in_stop, 1'b1);
		chk(wake_rx_valid, 1'b0);
		step(3);
		chk(in_stop, 1'b1);
		frame_wake(1'b1);
		chk(nmi_req, 1'b1);
		chk(comm_hold, 1'b1);
		chk(wake_rx_valid, 1'b0);
		$display("mid-frame stop test done");
	endtask
	task automatic give_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Reset, then the scenarios in order
	initial begin
		{reset, wait_instr, stop_instr, sel, ie, start} = 6'h20;
		{tx_data_in, tx_drive_in} = 2'h3;
		step(5);
		reset = 1'b0;
		t_wait;
		t_wait_masked;
		t_stop;
		t_wait_stop;
		t_mid;
		give_verdict;
	end
endmodule
`default_nettype wire
